/* design/dwp_winch_ctrl.sv */
// Winch position control: channel decode, limits, motion and power gating
`timescale 1ns/1ns
`include "dwp_map.svh"
module dwp_winch_ctrl #(
   parameter int unsigned STEP_CYC = `DWP_STEP_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [8:0] start_addr,
   input wire logic frame_valid,
   input wire logic [8:0] frame_slot,
   input wire logic [7:0] frame_data,
   input wire logic link_ok,
   input wire logic overload,
   input wire logic hard_top,
   input wire logic hard_bottom,
   input wire logic pos_saved,
   input wire logic setup_mode,
   output logic motor_power,
   output logic motor_step,
   output logic motor_up,
   output logic [15:0] position,
   output logic ref_valid,
   output logic error,
   output logic [2:0] error_code
);
   // ---------------------------------------------------------------
   // State record
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] pos_hi;
      logic [7:0] pos_lo;
      logic [7:0] speed;
      logic [7:0] safety;
      logic [7:0] top_ch;
      logic [7:0] bot_ch;
      logic [15:0] pos;
      logic [15:0] soft_top;
      logic [15:0] soft_bot;
      logic ref_ok;
      dwp_pkg::dwp_mode_e mode;
      dwp_pkg::dwp_motor_s motor;
      dwp_pkg::dwp_err_s err;
   } dwp_st_s;
   dwp_st_s st;
   dwp_st_s next_st;

   // ---------------------------------------------------------------
   // Combinational helpers
   // ---------------------------------------------------------------
   logic step_tick; // Speed-scaled motion pulse
   logic enabled; // Safety channel inside band
   logic [15:0] target; // Commanded position
   logic [15:0] goal; // Target clamped to soft range
   logic want_up; // Direction toward goal
   logic at_goal; // Goal reached
   logic jog_up; // Setup raise request
   logic jog_dn; // Setup lower request
   logic hard_block; // Hard limit blocks direction
   logic run_block; // Hard limit blocks the wanted direction
   logic moving; // Motion wanted this cycle
   logic [9:0] rel; // Slot relative to start
   logic gen_run; // Run request to rate generator
   logic [7:0] gen_speed; // Speed given to generator

   // Enable band check on 8-bit level
   assign enabled = (st.safety >= 8'(`DWP_EN_LO_LVL)) && (st.safety <= 8'(`DWP_EN_HI_LVL));
   // Target from MSB and LSB channels
   assign target = {st.pos_hi, st.pos_lo};
   // Full scale maps to soft top, zero to soft bottom
   assign goal = (target > st.soft_top) ? st.soft_top :
                 (target < st.soft_bot) ? st.soft_bot : target;
   assign want_up = goal > st.pos;
   assign at_goal = goal == st.pos;
   assign jog_up = st.top_ch >= `DWP_JOG_LVL;
   assign jog_dn = st.bot_ch >= `DWP_JOG_LVL;
   assign rel = {1'b0, frame_slot} - {1'b0, start_addr};
   // Hard limits override any command
   assign hard_block = (st.motor.dir_up && hard_top) || (!st.motor.dir_up && hard_bottom);
   // Reversal at a switch must not step past it
   assign run_block = want_up ? hard_top : hard_bottom;
   assign gen_run = (st.mode == dwp_pkg::DWP_RUN && !at_goal) ||
                    (st.mode == dwp_pkg::DWP_SETUP && (jog_up || jog_dn));
   // Setup jogs at the speed channel too; zero speed stops
   assign gen_speed = st.speed;

   // ---------------------------------------------------------------
   // Step rate generator
   // ---------------------------------------------------------------
   dwp_rate_gen #(
      .STEP_CYC(STEP_CYC)
   ) u_rate (
      .clk(clk),
      .srst(srst),
      .run(gen_run),
      .speed(gen_speed),
      .step(step_tick)
   );

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      moving = 1'b0;
      next_st.motor.step = 1'b0;
      // Capture the six channels of our window
      if (frame_valid && rel < 10'(`DWP_NUM_CH) && frame_slot >= start_addr) begin
         unique case (rel[2:0])
            3'h0: next_st.pos_hi = frame_data;
            3'h1: next_st.pos_lo = frame_data;
            3'h2: next_st.speed = frame_data;
            3'h3: next_st.safety = frame_data;
            3'h4: next_st.top_ch = frame_data;
            default: next_st.bot_ch = frame_data;
         endcase
      end
      // Sticky fault flags
      if (!link_ok) begin
         next_st.err.link_lost = 1'b1;
      end
      if (overload) begin
         next_st.err.overload = 1'b1;
      end
      if (st.motor.power && hard_block) begin
         next_st.err.limit_hit = 1'b1;
      end
      unique case (st.mode)
         dwp_pkg::DWP_IDLE: begin
            next_st.motor.power = 1'b0;
            // Saved position gives a reference at once
            if (!st.ref_ok && pos_saved) begin
               next_st.ref_ok = 1'b1;
            end
            // Reset command re-establishes reference
            if (!st.ref_ok && !pos_saved && jog_up && enabled && hard_top) begin
               next_st.ref_ok = 1'b1;
               next_st.pos = st.soft_top;
            end
            if (enabled && link_ok && !overload) begin
               if (setup_mode) begin
                  next_st.mode = dwp_pkg::DWP_SETUP;
               end else if (st.ref_ok) begin
                  next_st.mode = dwp_pkg::DWP_RUN;
               end
            end
         end
         dwp_pkg::DWP_RUN: begin
            // Drive toward goal at capped speed
            next_st.motor.dir_up = want_up;
            moving = !at_goal && st.speed != 8'h00;
            next_st.motor.power = moving;
            if (step_tick && moving && !run_block) begin
               next_st.motor.step = 1'b1;
               next_st.pos = want_up ? st.pos + 16'h0001 : st.pos - 16'h0001;
            end
            // Leave on disable, setup or fault
            if (!enabled || setup_mode) begin
               next_st.mode = dwp_pkg::DWP_IDLE;
               next_st.motor.power = 1'b0;
            end
         end
         dwp_pkg::DWP_SETUP: begin
            // Five raises to a stop, six lowers
            next_st.motor.dir_up = jog_up;
            moving = (jog_up && !hard_top) || (jog_dn && !jog_up && !hard_bottom);
            next_st.motor.power = moving && st.speed != 8'h00;
            if (step_tick && moving && st.speed != 8'h00) begin
               next_st.motor.step = 1'b1;
               next_st.pos = jog_up ? st.pos + 16'h0001 : st.pos - 16'h0001;
            end
            // Soft limits follow the jogged position
            // Limit takes the new count, so the last jog step is not lost
            if (jog_up) begin
               next_st.soft_top = next_st.pos;
               next_st.ref_ok = 1'b1;
            end else if (jog_dn) begin
               next_st.soft_bot = next_st.pos;
            end
            if (!enabled || !setup_mode) begin
               next_st.mode = dwp_pkg::DWP_IDLE;
               next_st.motor.power = 1'b0;
            end
         end
         dwp_pkg::DWP_FAULT: begin
            next_st.motor.power = 1'b0;
            // Safety channel at zero clears faults; limits kept
            if (st.safety == 8'h00 && link_ok && !overload) begin
               next_st.err = '0;
               next_st.mode = dwp_pkg::DWP_IDLE;
            end
         end
         default: begin
            next_st.mode = dwp_pkg::DWP_FAULT;
            next_st.motor.power = 1'b0;
         end
      endcase
      // Any fault removes drive at once
      if (!link_ok || overload || (st.motor.power && hard_block)) begin
         next_st.mode = dwp_pkg::DWP_FAULT;
         next_st.motor.power = 1'b0;
         // A step cut by the fault must not move the count
         if (next_st.motor.step) begin
            next_st.pos = st.pos;
         end
         next_st.motor.step = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
         st.soft_top <= `DWP_SOFT_TOP_RST;
         st.soft_bot <= `DWP_SOFT_BOT_RST;
         st.mode <= dwp_pkg::DWP_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all from flip-flops
   // ---------------------------------------------------------------
   assign motor_power = st.motor.power;
   assign motor_step = st.motor.step;
   assign motor_up = st.motor.dir_up;
   assign position = st.pos;
   assign ref_valid = st.ref_ok;
   assign error = |st.err;
   assign error_code = st.err;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_lost;
      !link_ok;
   endsequence
   sequence s_first_slot;
      frame_valid && frame_slot == start_addr;
   endsequence
   sequence s_step_up;
      motor_step && motor_up;
   endsequence
   sequence s_step_down;
      motor_step && !motor_up;
   endsequence

   // Power gating
   a_power_needs_enable: assert property (@(posedge clk) disable iff (srst)
      motor_power |-> $past(enabled)) else $error("power without enable");
   a_idle_no_power: assert property (@(posedge clk) disable iff (srst)
      st.mode == dwp_pkg::DWP_IDLE && $past(st.mode) == dwp_pkg::DWP_IDLE |-> !motor_power)
      else $error("power in idle");
   a_link_drop_off: assert property (@(posedge clk) disable iff (srst)
      s_lost |=> !motor_power && error) else $error("power kept on link loss");
   a_overload_off: assert property (@(posedge clk) disable iff (srst)
      overload |=> !motor_power) else $error("power kept on overload");
   a_speed_power: assert property (@(posedge clk) disable iff (srst)
      motor_power |-> $past(st.speed) != 8'h00) else $error("power at zero speed");
   a_fault_power: assert property (@(posedge clk) disable iff (srst)
      st.mode == dwp_pkg::DWP_FAULT |-> !motor_power) else $error("power in fault");
   a_error_fault: assert property (@(posedge clk) disable iff (srst)
      error |-> st.mode == dwp_pkg::DWP_FAULT) else $error("error outside fault");
   a_ref_run: assert property (@(posedge clk) disable iff (srst)
      st.mode == dwp_pkg::DWP_RUN |-> ref_valid) else $error("run without reference");

   // Motion and position count
   a_zero_speed: assert property (@(posedge clk) disable iff (srst)
      (st.speed == 8'h00) |=> !motor_step) else $error("step at zero speed");
   a_step_pos: assert property (@(posedge clk) disable iff (srst)
      s_step_up |-> position == $past(position) + 16'h0001)
      else $error("step did not move up");
   a_step_down: assert property (@(posedge clk) disable iff (srst)
      s_step_down |-> position == $past(position) - 16'h0001)
      else $error("step did not move down");
   a_hard_top: assert property (@(posedge clk) disable iff (srst)
      s_step_up |-> !$past(hard_top)) else $error("step past top");
   a_hard_bottom: assert property (@(posedge clk) disable iff (srst)
      s_step_down |-> !$past(hard_bottom)) else $error("step past bottom");
   a_run_goal: assert property (@(posedge clk) disable iff (srst)
      st.mode == dwp_pkg::DWP_RUN && motor_step |-> $past(st.pos) != $past(goal))
      else $error("step at goal");

   // Channel decode
   a_slot_capture: assert property (@(posedge clk) disable iff (srst)
      s_first_slot |=> st.pos_hi == $past(frame_data)) else $error("first slot not taken");
   a_band_low: assert property (@(posedge clk) disable iff (srst)
      st.safety < 8'(`DWP_EN_LO_LVL) |-> !enabled) else $error("band low wrong");
   a_band_high: assert property (@(posedge clk) disable iff (srst)
      st.safety > 8'(`DWP_EN_HI_LVL) |-> !enabled) else $error("band high wrong");
endmodule

/* design/dwp_map.svh */
// Offsets, field positions, levels and timing counts of the winch position control
`ifndef DWP_MAP_SVH
`define DWP_MAP_SVH
// ---------------------------------------------------------------
// Channel layout
// ---------------------------------------------------------------
`define DWP_NUM_CH 6
`define DWP_CH_POS_HI 0
`define DWP_CH_POS_LO 1
`define DWP_CH_SPEED 2
`define DWP_CH_SAFETY 3
`define DWP_CH_TOP 4
`define DWP_CH_BOTTOM 5
// ---------------------------------------------------------------
// Levels (8-bit): enable band derived from percentages, jog level fixed
// ---------------------------------------------------------------
`define DWP_EN_LO_PCT 50
`define DWP_EN_HI_PCT 55
`define DWP_EN_LO_LVL ((`DWP_EN_LO_PCT * 255 + 99) / 100)
`define DWP_EN_HI_LVL ((`DWP_EN_HI_PCT * 255) / 100)
`define DWP_JOG_LVL 8'h80
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define DWP_SOFT_TOP_RST 16'hFFFF
`define DWP_SOFT_BOT_RST 16'h0000
// ---------------------------------------------------------------
// Timing: speed step period
// ---------------------------------------------------------------
`define DWP_CLK_MHZ 25
`define DWP_STEP_US 40
`define DWP_STEP_CYC (`DWP_STEP_US * `DWP_CLK_MHZ)
`endif

/* design/dwp_pkg.sv */
// Types of the winch position control
package dwp_pkg;
   // Motion controller state, one-hot
   typedef enum logic [3:0] {
      DWP_IDLE = 4'h1,
      DWP_RUN = 4'h2,
      DWP_SETUP = 4'h4,
      DWP_FAULT = 4'h8
   } dwp_mode_e;
   // Motor command bundle
   typedef struct packed {
      logic power;
      logic step;
      logic dir_up;
   } dwp_motor_s;
   // Fault flags
   typedef struct packed {
      logic link_lost;
      logic overload;
      logic limit_hit;
   } dwp_err_s;
endpackage

/* design/dwp_rate_gen.sv */
// Speed-scaled step pulse generator
`timescale 1ns/1ns
module dwp_rate_gen #(
   parameter int unsigned STEP_CYC = 1000
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic run,
   input wire logic [7:0] speed,
   output logic step
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] div;
      logic [8:0] acc;
      logic step;
   } dwp_rg_s;
   dwp_rg_s st;
   dwp_rg_s next_st;
   localparam logic [15:0] DIV_LAST = 16'(STEP_CYC - 1);

   // Accumulate speed once per base period, step on overflow
   always_comb begin
      next_st = st;
      next_st.step = 1'b0;
      if (!run || speed == 8'h00) begin
         next_st.div = 16'h0000;
         next_st.acc = 9'h000;
      end else if (st.div == DIV_LAST) begin
         next_st.div = 16'h0000;
         next_st.acc = {1'b0, st.acc[7:0]} + {1'b0, speed};
         next_st.step = next_st.acc[8];
      end else begin
         next_st.div = st.div + 16'h0001;
      end
   end

   // Register state
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign step = st.step;
endmodule

/* verif/dwp_desk_model.sv */
// Lighting desk model that streams one frame of channel levels per request
`timescale 1ns/1ns
module dwp_desk_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic [8:0] start_addr,
   input wire logic [47:0] levels,
   input wire logic send,
   output logic frame_valid,
   output logic [8:0] frame_slot,
   output logic [7:0] frame_data
);
   // ---------------------------------------------------------------
   // Frame state
   // ---------------------------------------------------------------
   logic [63:0] sh; // Pending bytes, first at the top
   logic [3:0] cnt; // Bytes still to send
   // Sends slot start-1, the six channels from start, then slot start+6
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt <= 4'h0;
         sh <= 64'h0;
         frame_valid <= 1'b0;
         frame_slot <= 9'h000;
         frame_data <= 8'h00;
      end else if (cnt != 4'h0) begin
         // One byte per cycle, slots back to back
         frame_valid <= 1'b1;
         frame_slot <= start_addr + 9'h007 - {5'h00, cnt};
         frame_data <= sh[63:56];
         sh <= {sh[55:0], 8'h00};
         cnt <= cnt - 4'h1;
      end else if (send) begin
         // Outer slots carry all-ones so that a wrong window shows
         sh <= {8'hFF, levels, 8'hFF};
         cnt <= 4'h8;
         frame_valid <= 1'b0;
      end else begin
         // Between frames the lines hold no stale value
         frame_valid <= 1'b0;
         frame_slot <= ~frame_slot;
         frame_data <= ~frame_data;
      end
   end
endmodule

/* verif/dwp_winch_ctrl_bench.sv */
// Self-checking bench of the winch position control
`timescale 1ns/1ns
module dwp_winch_ctrl_bench;
   // ---------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [8:0] start_addr = 9'h010;
   logic [47:0] levels = 48'h0;
   logic send = 1'b0;
   logic link_ok = 1'b1;
   logic overload = 1'b0;
   logic hard_top = 1'b0;
   logic hard_bottom = 1'b0;
   logic pos_saved = 1'b0;
   logic setup_mode = 1'b0;
   logic frame_valid, motor_power, motor_step, motor_up, ref_valid, error;
   logic [8:0] frame_slot;
   logic [7:0] frame_data;
   logic [15:0] position, p0;
   logic [2:0] error_code;
   logic [7:0] band [4] = '{8'h7F, 8'h8D, 8'h80, 8'h8C}; // Levels around the band
   bit moves [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   logic [2:0] codes [3] = '{3'h4, 3'h2, 3'h1}; // Link lost, overload, limit
   int fail_count = 0;
   int compares = 0;
   int cyc = 0;
   int up_steps = 0;
   int dn_steps = 0;
   int u0, d0, c0;
   // Clock of 40 ns
   always #20 clk = ~clk;
   // ---------------------------------------------------------------
   // Instances
   // ---------------------------------------------------------------
   dwp_desk_model i_dwp_desk_model (.clk(clk), .srst(srst), .start_addr(start_addr),
      .levels(levels), .send(send), .frame_valid(frame_valid), .frame_slot(frame_slot),
      .frame_data(frame_data));
   dwp_winch_ctrl #(.STEP_CYC(2)) i_dwp_winch_ctrl (.clk(clk), .srst(srst),
      .start_addr(start_addr), .frame_valid(frame_valid), .frame_slot(frame_slot),
      .frame_data(frame_data), .link_ok(link_ok), .overload(overload), .hard_top(hard_top),
      .hard_bottom(hard_bottom), .pos_saved(pos_saved), .setup_mode(setup_mode),
      .motor_power(motor_power), .motor_step(motor_step), .motor_up(motor_up),
      .position(position), .ref_valid(ref_valid), .error(error), .error_code(error_code));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   // Counts a comparison and reports a mismatch
   task automatic check(input bit ok, input string msg);
      compares++;
      if (!ok) begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   // Prints the counts and the verdict, then stops
   task automatic results();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One desk frame, then the fixed decode and motor latency
   task automatic send_frame(input logic [15:0] tgt, input logic [7:0] spd,
      input logic [7:0] safe, input logic [7:0] top, input logic [7:0] bot);
      @(posedge clk);
      levels <= {tgt, spd, safe, top, bot};
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   // Bounded wait for a position, then lets the last step settle
   task automatic wait_pos(input logic [15:0] t);
      for (int n = 0; n < 2000 && position !== t; n++) @(posedge clk);
      repeat (2) @(posedge clk);
   endtask
   // Step counters and the run-time ceiling
   always @(posedge clk) begin
      cyc++;
      if (motor_step === 1'b1 && motor_up === 1'b1) begin
         up_steps++;
      end
      if (motor_step === 1'b1 && motor_up === 1'b0) begin
         dn_steps++;
      end
      if (cyc == 30000) begin
         fail_count++;
         results();
      end
   end
   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      check(motor_power === 1'b0 && position === 16'h0000 && error_code === 3'h0, "reset");
      // Enabled but no reference yet: no motion
      send_frame(16'h0100, 8'hFF, 8'h82, 8'h00, 8'h00);
      repeat (50) @(posedge clk);
      check(ref_valid === 1'b0 && position === 16'h0000, "moved unreferenced");
      // Reference taken at the hard top with channel five high
      hard_top <= 1'b1;
      send_frame(16'hFFFF, 8'hFF, 8'h82, 8'h80, 8'h00);
      check(ref_valid === 1'b1 && position === 16'hFFFF, "no reference");
      hard_top <= 1'b0;
      // Safety band edges, down moves of 0x0102
      for (int i = 0; i < 4; i++) begin
         p0 = position;
         d0 = dn_steps;
         send_frame(p0 - 16'h0102, 8'hFF, band[i], 8'h00, 8'h00);
         if (moves[i]) begin
            wait_pos(p0 - 16'h0102);
            check(position === p0 - 16'h0102 && dn_steps - d0 == 258, "band move");
         end else begin
            repeat (100) @(posedge clk);
            check(position === p0 && motor_power === 1'b0, "band refused");
         end
      end
      // Zero speed holds, a slow speed moves up at a limited rate
      p0 = position;
      send_frame(p0 + 16'h0010, 8'h00, 8'h82, 8'h00, 8'h00);
      repeat (100) @(posedge clk);
      check(position === p0, "moved at zero speed");
      u0 = up_steps;
      c0 = cyc;
      send_frame(p0 + 16'h0010, 8'h40, 8'h82, 8'h00, 8'h00);
      wait_pos(p0 + 16'h0010);
      check(position === p0 + 16'h0010 && up_steps - u0 == 16, "up move");
      check(cyc - c0 >= 100, "speed not limited");
      // Link loss, overload and hard limit in mid-move
      for (int i = 0; i < 3; i++) begin
         send_frame(position - 16'h0100, 8'hFF, 8'h82, 8'h00, 8'h00);
         {link_ok, overload, hard_bottom} <= {~codes[i][2], codes[i][1], codes[i][0]};
         repeat (3) @(posedge clk);
         p0 = position;
         check(motor_power === 1'b0 && error === 1'b1 && error_code === codes[i], "fault");
         repeat (20) @(posedge clk);
         check(position === p0, "moved in fault");
         {link_ok, overload, hard_bottom} <= 3'b100;
         send_frame(position, 8'h00, 8'h00, 8'h00, 8'h00);
         check(error === 1'b0, "fault kept");
      end
      // Setup raise on channel five sets the soft top
      setup_mode <= 1'b1;
      p0 = position;
      send_frame(p0, 8'hFF, 8'h82, 8'h80, 8'h00);
      send_frame(p0, 8'hFF, 8'h82, 8'h00, 8'h00);
      repeat (5) @(posedge clk);
      check(position > p0, "setup raise");
      p0 = position;
      setup_mode <= 1'b0;
      send_frame(16'hFFFF, 8'hFF, 8'h82, 8'h00, 8'h00);
      repeat (100) @(posedge clk);
      check(position === p0, "soft top passed");
      results();
   end
endmodule
